// *** design/crd_pkg.sv ***
// Constants and types shared by the core reset domain control design
`default_nettype none
package crd_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_MSTATE = 5'h08;
    localparam logic [4:0] ADDR_BOOT_ADDR = 5'h0C;
    localparam logic [4:0] ADDR_BOOT_MODE = 5'h10;
    localparam logic [4:0] ADDR_DBG_CTRL = 5'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_EXIT_DBG = 2;
    localparam int ST_WAKEUP = 3;
    localparam int ST_SESSION = 4;
    localparam int ST_HALTED = 5;
    localparam int ST_STOPPED = 6;
    localparam int ST_RSRV = 7;
    localparam int ST_CPU_RST = 8;
    localparam int ST_DBG_RST = 9;
    localparam int DBG_DRIVE = 0;
    localparam int DBG_IR_LSB = 4;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int BASE_W = 30;
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [3:0] MSTATE_RST = 4'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Low-power modes and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LPM_NONE = 2'h0,
        LPM_DOZE = 2'h1,
        LPM_NAP = 2'h2,
        LPM_SLEEP = 2'h3
    } crd_lp_mode_t;

    typedef enum logic [1:0] {
        LP_RUN = 2'h0,
        LP_LOW = 2'h1,
        LP_WAKE = 2'h3
    } crd_lp_state_t;

endpackage
`default_nettype wire

// *** design/crd_sync.sv ***
// Two-flop level synchroniser with a constant reset value
`timescale 1ns/10ps
`default_nettype none
module crd_sync #(
    parameter int WIDTH = 1,
    parameter logic RST_VAL = 1'b0
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= {WIDTH{RST_VAL}};
            q <= {WIDTH{RST_VAL}};
        end else if (ce) begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** design/crd_dbg.sv ***
// Debug-domain logic: request drive, instruction shift and key output
`timescale 1ns/10ps
`default_nettype none
module crd_dbg (
    // Clock and control
    input wire logic clk,
    input wire logic ce,
    input wire logic dbg_rst,
    // Register access
    input wire logic dbg_wr,
    input wire logic dbg_wdata,
    output logic drive_req,
    output logic [crd_pkg::IR_W-1:0] ir_value,
    // Test access
    input wire logic full_debug_enable,
    input wire logic key_in,
    input wire logic tap_capture_ir,
    input wire logic tap_shift_ir,
    input wire logic tdi,
    output logic tdo
);
    logic next_drive_req;
    logic [crd_pkg::IR_W-1:0] next_ir_value;
    logic next_tdo;

    always_comb begin
        next_drive_req = drive_req;
        next_ir_value = ir_value;
        next_tdo = tdo;
        if (dbg_wr) begin
            next_drive_req = dbg_wdata;
        end
        if (tap_capture_ir) begin
            next_ir_value = crd_pkg::IR_CAPTURE_VAL;
        end else if (tap_shift_ir) begin
            next_ir_value = {tdi, ir_value[crd_pkg::IR_W-1:1]};
            next_tdo = full_debug_enable ? ir_value[0] : key_in;
        end
    end

    always_ff @(posedge clk) begin
        if (dbg_rst) begin
            drive_req <= 1'b0;
            ir_value <= crd_pkg::IR_CAPTURE_VAL;
            tdo <= 1'b0;
        end else if (ce) begin
            drive_req <= next_drive_req;
            ir_value <= next_ir_value;
            tdo <= next_tdo;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic key_shift;
    assign key_shift = tap_shift_ir & ~tap_capture_ir & ~full_debug_enable
        & ce;

    AST_KEY_OUT: assert property (
        @(posedge clk) disable iff (dbg_rst)
        key_shift |=> (tdo == $past(key_in))
    ) else $error("key input not shifted out");

    AST_DBG_CLEAR: assert property (
        @(posedge clk)
        $past(dbg_rst) |-> (!drive_req && !tdo)
    ) else $error("debug state not cleared by reset");
endmodule
`default_nettype wire

// *** design/crd_top.sv ***
// Core reset domain control: reset domains, state outputs, register slave
//
// Overview of operation
// - Processor reset leaves debug logic untouched
// - Test reset clears debug side only
// - Debug registers reachable in run or reset
// - Later resets handled independently per domain
// - Por OR test reset clears debug logic
// - Por OR processor reset clears processor registers
// - Fully static; state kept with clock stopped
// - Base, endian, encoding inputs set boot defaults
// - Session indicator high in reset, low in session
// - Doze, nap, sleep only while in mode
// - Wake-up output asks clocks to restart
// - Locked debug shifts key input in IR shift
// - Debug request pad enable, cleared in debug reset
// - Four state enable bits mirrored on outputs
// - Processor reset synchronised before use
// - First fetch at base followed by two zeros
`timescale 1ns/10ps
`default_nettype none
module crd_top (
    // Clock, power-on reset, clock enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Domain resets
    input wire logic proc_reset_n,
    input wire logic test_reset_n,
    // Boot defaults
    input wire logic [crd_pkg::BASE_W-1:0] handler_base,
    input wire logic endian_sel,
    input wire logic encoding_sel,
    output logic [31:0] boot_fetch_addr,
    output logic boot_endian,
    output logic boot_encoding,
    output logic boot_fetch_req,
    // Low power
    input wire logic clock_running_ind,
    input wire logic ext_int_n,
    input wire logic crit_int_n,
    output logic doze,
    output logic nap,
    output logic sleep,
    output logic wakeup,
    // Debug
    input wire logic full_debug_enable,
    input wire logic debug_request_n,
    output logic debug_request_o,
    output logic debug_request_pad_oe,
    output logic debug_session_n,
    input wire logic key_in,
    input wire logic tap_capture_ir,
    input wire logic tap_shift_ir,
    input wire logic tdi,
    output logic tdo,
    // Processor state
    output logic [3:0] state_enable_mirror,
    input wire logic halt_req,
    output logic halted,
    input wire logic stop_req,
    output logic stopped,
    input wire logic rsrv_set,
    input wire logic rsrv_clr,
    output logic reservation
);
    // ------------------------------------------------------------
    // Reset domains
    // ------------------------------------------------------------
    logic proc_reset_sync_n;
    logic cpu_rst;
    logic dbg_rst;
    logic cpu_rst_d;

    crd_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_proc_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(proc_reset_n),
        .q(proc_reset_sync_n)
    );

    assign cpu_rst = rst | ~proc_reset_sync_n;
    assign dbg_rst = rst | ~test_reset_n;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic req;
    logic wr_fire;
    logic ctrl_wr;
    logic mstate_wr;
    logic dbg_wr;
    logic drive_req;
    logic [crd_pkg::IR_W-1:0] ir_value;
    logic [31:0] status_word;
    crd_pkg::crd_lp_mode_t lp_req;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~(ack & ce);
    assign wr_fire = avs_write & ack & ce;
    assign ctrl_wr = wr_fire & avs_byteenable[0]
        & (avs_address == crd_pkg::ADDR_CTRL);
    assign mstate_wr = wr_fire & avs_byteenable[0]
        & (avs_address == crd_pkg::ADDR_MSTATE);
    // debug access in any cpu state
    assign dbg_wr = wr_fire & avs_byteenable[0]
        & (avs_address == crd_pkg::ADDR_DBG_CTRL);

    always_comb begin
        next_ack = req & ~ack;
        next_readdata = avs_readdata;
        if (avs_read & ~ack) begin
            unique case (avs_address)
                crd_pkg::ADDR_CTRL: next_readdata = {30'h0000_0000, lp_req};
                crd_pkg::ADDR_STATUS: next_readdata = status_word;
                crd_pkg::ADDR_MSTATE:
                    next_readdata = {28'h000_0000, state_enable_mirror};
                crd_pkg::ADDR_BOOT_ADDR: next_readdata = boot_fetch_addr;
                crd_pkg::ADDR_BOOT_MODE:
                    next_readdata = {30'h0000_0000, boot_encoding,
                        boot_endian};
                crd_pkg::ADDR_DBG_CTRL:
                    next_readdata = {24'h00_0000, ir_value, 3'h0, drive_req};
                default: next_readdata = crd_pkg::RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
            avs_readdata <= crd_pkg::RDATA_RST;
        end else if (ce) begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // Debug domain
    // ------------------------------------------------------------
    // only debug reset reaches here
    crd_dbg u_dbg (
        .clk(clk),
        .ce(ce),
        .dbg_rst(dbg_rst),
        .dbg_wr(dbg_wr),
        .dbg_wdata(avs_writedata[crd_pkg::DBG_DRIVE]),
        .drive_req(drive_req),
        .ir_value(ir_value),
        .full_debug_enable(full_debug_enable),
        .key_in(key_in),
        .tap_capture_ir(tap_capture_ir),
        .tap_shift_ir(tap_shift_ir),
        .tdi(tdi),
        .tdo(tdo)
    );

    assign debug_request_pad_oe = drive_req;
    assign debug_request_o = 1'b0;

    // ------------------------------------------------------------
    // Processor domain
    // ------------------------------------------------------------
    crd_pkg::crd_lp_state_t lp_state;
    crd_pkg::crd_lp_state_t next_lp_state;
    crd_pkg::crd_lp_mode_t lp_mode;
    crd_pkg::crd_lp_mode_t next_lp_mode;
    crd_pkg::crd_lp_mode_t next_lp_req;
    logic [2:0] next_lp_ind;
    logic next_wakeup;
    logic session;
    logic next_session;
    logic next_halted;
    logic next_stopped;
    logic next_reservation;
    logic [3:0] next_mirror;
    logic wake_evt;
    logic dbg_enter;

    assign dbg_enter = ~debug_request_n & full_debug_enable;
    assign wake_evt = (~ext_int_n & state_enable_mirror[0])
        | (~crit_int_n & state_enable_mirror[2]) | ~debug_request_n;

    always_comb begin
        next_lp_state = lp_state;
        next_lp_mode = lp_mode;
        next_lp_req = lp_req;
        next_wakeup = wakeup;
        next_mirror = state_enable_mirror;
        if (ctrl_wr) begin
            next_lp_req = crd_pkg::crd_lp_mode_t'(avs_writedata[1:0]);
        end
        unique case (lp_state)
            crd_pkg::LP_RUN: begin
                if (lp_req != crd_pkg::LPM_NONE && !session) begin
                    next_lp_state = crd_pkg::LP_LOW;
                    next_lp_mode = lp_req;
                    next_lp_req = crd_pkg::LPM_NONE;
                end
            end
            crd_pkg::LP_LOW: begin
                if (wake_evt) begin
                    next_lp_state = crd_pkg::LP_WAKE;
                    next_wakeup = 1'b1;
                end
            end
            crd_pkg::LP_WAKE: begin
                if (clock_running_ind) begin
                    next_lp_state = crd_pkg::LP_RUN;
                    next_lp_mode = crd_pkg::LPM_NONE;
                    next_wakeup = 1'b0;
                end
            end
            default: begin
                next_lp_state = crd_pkg::LP_RUN;
                next_lp_mode = crd_pkg::LPM_NONE;
                next_wakeup = 1'b0;
            end
        endcase
        next_lp_ind = 3'h0;
        if (next_lp_state != crd_pkg::LP_RUN) begin
            next_lp_ind[0] = (next_lp_mode == crd_pkg::LPM_DOZE);
            next_lp_ind[1] = (next_lp_mode == crd_pkg::LPM_NAP);
            next_lp_ind[2] = (next_lp_mode == crd_pkg::LPM_SLEEP);
        end
        next_session = dbg_enter | (session
            & ~(ctrl_wr & avs_writedata[crd_pkg::CTRL_EXIT_DBG]));
        next_halted = halt_req;
        next_stopped = stop_req;
        next_reservation = rsrv_set | (reservation & ~rsrv_clr);
        if (mstate_wr) begin
            next_mirror = avs_writedata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (cpu_rst) begin
            lp_state <= crd_pkg::LP_RUN;
            lp_mode <= crd_pkg::LPM_NONE;
            lp_req <= crd_pkg::LPM_NONE;
            {sleep, nap, doze} <= 3'h0;
            wakeup <= 1'b0;
            session <= 1'b0;
            halted <= 1'b0;
            stopped <= 1'b0;
            reservation <= 1'b0;
            state_enable_mirror <= crd_pkg::MSTATE_RST;
        end else if (ce) begin
            lp_state <= next_lp_state;
            lp_mode <= next_lp_mode;
            lp_req <= next_lp_req;
            {sleep, nap, doze} <= next_lp_ind;
            wakeup <= next_wakeup;
            session <= next_session;
            halted <= next_halted;
            stopped <= next_stopped;
            reservation <= next_reservation;
            state_enable_mirror <= next_mirror;
        end
    end

    assign debug_session_n = ~session;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[2:0] = {sleep, nap, doze};
        status_word[crd_pkg::ST_WAKEUP] = wakeup;
        status_word[crd_pkg::ST_SESSION] = session;
        status_word[crd_pkg::ST_HALTED] = halted;
        status_word[crd_pkg::ST_STOPPED] = stopped;
        status_word[crd_pkg::ST_RSRV] = reservation;
        status_word[crd_pkg::ST_CPU_RST] = cpu_rst;
        status_word[crd_pkg::ST_DBG_RST] = dbg_rst;
    end

    // ------------------------------------------------------------
    // Boot defaults
    // ------------------------------------------------------------
    logic [31:0] next_boot_addr;
    logic next_boot_endian;
    logic next_boot_encoding;
    logic next_fetch_req;

    always_comb begin
        next_boot_addr = boot_fetch_addr;
        next_boot_endian = boot_endian;
        next_boot_encoding = boot_encoding;
        if (cpu_rst) begin
            next_boot_addr = {handler_base, 2'b00};
            next_boot_endian = endian_sel;
            next_boot_encoding = encoding_sel;
        end
        next_fetch_req = cpu_rst_d & ~cpu_rst;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            boot_fetch_addr <= 32'h0000_0000;
            boot_endian <= 1'b0;
            boot_encoding <= 1'b0;
            boot_fetch_req <= 1'b0;
            cpu_rst_d <= 1'b1;
        end else if (ce) begin
            boot_fetch_addr <= next_boot_addr;
            boot_endian <= next_boot_endian;
            boot_encoding <= next_boot_encoding;
            boot_fetch_req <= next_fetch_req;
            cpu_rst_d <= cpu_rst;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [1:0] ce_hist;
    logic enter_now;
    logic halt_now;
    logic dbg_quiet;
    logic cpu_quiet;
    logic [3:0] wdata_low;

    assign enter_now = dbg_enter & ce & ~cpu_rst;
    assign halt_now = halt_req & ce & ~cpu_rst;
    assign dbg_quiet = ~dbg_rst & ~dbg_wr;
    assign cpu_quiet = ~test_reset_n & ~cpu_rst & ~mstate_wr;
    assign wdata_low = avs_writedata[3:0];

    always_ff @(posedge clk) begin
        ce_hist <= {ce_hist[0], ce};
    end

    AST_DBG_ISOLATE: assert property (
        @(posedge clk) disable iff (rst)
        $past(dbg_quiet) |-> (drive_req == $past(drive_req))
    ) else $error("debug drive changed without cause");

    AST_CPU_KEEPS: assert property (
        @(posedge clk) disable iff (rst)
        $past(cpu_quiet) |-> $stable(state_enable_mirror)
    ) else $error("test reset disturbed processor state");

    AST_CPU_CLEAR: assert property (
        @(posedge clk)
        $past(cpu_rst) |-> (state_enable_mirror == 4'h0 && !halted
            && !wakeup && !reservation)
    ) else $error("processor state not cleared");

    AST_SESSION: assert property (
        @(posedge clk) disable iff (rst)
        $past(enter_now) |-> !debug_session_n
    ) else $error("session indicator not asserted");

    AST_LP_IND: assert property (
        @(posedge clk) disable iff (rst)
        (lp_state == crd_pkg::LP_RUN) |-> ({sleep, nap, doze} == 3'h0)
    ) else $error("low-power indicator outside its mode");

    AST_LP_ONE: assert property (
        @(posedge clk) disable iff (rst)
        $onehot0({sleep, nap, doze})
    ) else $error("more than one low-power indicator");

    AST_WAKE_DROP: assert property (
        @(posedge clk) disable iff (rst)
        (lp_state == crd_pkg::LP_WAKE && clock_running_ind && ce)
            |=> (!wakeup && lp_state == crd_pkg::LP_RUN)
    ) else $error("wake-up not released when clocks run");

    AST_MIRROR: assert property (
        @(posedge clk) disable iff (rst)
        (mstate_wr && !cpu_rst) |=> (state_enable_mirror == $past(wdata_low))
    ) else $error("state enable mirror not updated");

    AST_BOOT_ADDR: assert property (
        @(posedge clk) disable iff (rst)
        (boot_fetch_req && ce_hist == 2'b11)
            |-> (boot_fetch_addr == {$past(handler_base, 2), 2'b00})
    ) else $error("boot fetch address wrong");

    AST_HALT: assert property (
        @(posedge clk) disable iff (rst)
        $past(halt_now) |-> halted
    ) else $error("held halt request not answered");
endmodule
`default_nettype wire

// *** tb/crd_sysctl_model.sv ***
// Reset and clock controller model standing outside the core
`timescale 1ns/10ps
`default_nettype none
module crd_sysctl_model (
    // Clock and bench control
    input wire logic clk,
    input wire logic proc_hold,
    input wire logic test_hold,
    input wire logic slow,
    // Core side
    input wire logic lp_any,
    input wire logic wakeup,
    output logic proc_reset_n,
    output logic test_reset_n,
    output logic clock_running_ind
);
    int cnt;
    initial begin
        {proc_reset_n, test_reset_n} = 2'h0;
        clock_running_ind = 1'b1;
        cnt = 0;
    end
    always @(posedge clk) begin
        proc_reset_n <= ~proc_hold;
        test_reset_n <= ~test_hold;
    end
    // flag high only while clock toggles
    always @(posedge clk) begin
        cnt <= wakeup ? cnt + 1 : 0;
        if (lp_any && !wakeup)
            clock_running_ind <= 1'b0;
        else if (wakeup && cnt >= (slow ? 6 : 1))
            clock_running_ind <= 1'b1;
    end
endmodule
`default_nettype wire

// *** tb/crd_top_tb_top.sv ***
// Self-checking bench for the core reset domain control block
`timescale 1ns/10ps
`default_nettype none
module crd_top_tb_top;
    // ----------------
    // Signals and instances
    // ----------------
    logic clk, rst, ce, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable, state_enable_mirror;
    logic [31:0] avs_writedata, avs_readdata, boot_fetch_addr, q;
    logic [crd_pkg::BASE_W-1:0] handler_base;
    logic proc_reset_n, test_reset_n, endian_sel, encoding_sel;
    logic boot_endian, boot_encoding, boot_fetch_req, clock_running_ind;
    logic ext_int_n, crit_int_n, doze, nap, sleep, wakeup, tdo;
    logic full_debug_enable, debug_request_n, debug_request_o, key_in;
    logic debug_request_pad_oe, debug_session_n, tap_capture_ir, tdi;
    logic tap_shift_ir, halt_req, halted, stop_req, stopped;
    logic rsrv_set, rsrv_clr, reservation, proc_hold, test_hold, slow;
    int n_fail, comparisons;
    wire logic [1:0] obs = {boot_fetch_req, wakeup};

    crd_top u_crd_top (.*);
    crd_sysctl_model u_crd_sysctl_model (.clk, .proc_hold, .test_hold,
        .slow, .lp_any(doze | nap | sleep), .wakeup, .proc_reset_n,
        .test_reset_n, .clock_running_ind);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------
    // Shared tasks
    // ----------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_for(input int b, input logic v);
        int i;
        for (i = 0; i < 40 && obs[b] !== v; i++)
            @(negedge clk);
        if (obs[b] !== v) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, ~w, a, d};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 40);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            tally_and_finish();
        end
        q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_boot(input logic [29:0] base, input logic [1:0] m);
        @(posedge clk);
        {proc_hold, handler_base, endian_sel, encoding_sel} <= {1'b1, base, m};
        settle(4);
        @(posedge clk);
        proc_hold <= 1'b0;
        wait_for(1, 1'b1);
        chk(boot_fetch_addr, {base, 2'b00});
        chk({boot_endian, boot_encoding}, m);
        bus(1'b0, crd_pkg::ADDR_BOOT_ADDR, 32'h0);
        chk(q, {base, 2'b00});
        bus(1'b0, crd_pkg::ADDR_BOOT_MODE, 32'h0);
        chk(q[1:0], {m[0], m[1]});
    endtask
    task automatic t_domains();
        bus(1'b1, crd_pkg::ADDR_MSTATE, 32'hA);
        bus(1'b1, crd_pkg::ADDR_DBG_CTRL, 32'h1);
        avs_byteenable <= 4'hE;
        bus(1'b1, crd_pkg::ADDR_MSTATE, 32'h5);
        avs_byteenable <= 4'hF;
        bus(1'b0, 5'h1C, 32'h0);
        chk(q, 32'h0);
        settle(1);
        chk({debug_request_pad_oe, state_enable_mirror}, 5'h1A);
        @(posedge clk);
        {proc_hold, rsrv_set} <= 2'h3;
        settle(1);
        chk({reservation, debug_request_o}, 2'h2);
        settle(4);
        chk({debug_request_pad_oe, state_enable_mirror}, 5'h10);
        chk(reservation, 1'b0);
        bus(1'b0, crd_pkg::ADDR_DBG_CTRL, 32'h0);
        chk(q[0], 1'b1);
        bus(1'b0, crd_pkg::ADDR_STATUS, 32'h0);
        chk(q[9:8], 2'h1);
        {proc_hold, rsrv_set} <= 2'h0;
        settle(5);
        bus(1'b1, crd_pkg::ADDR_MSTATE, 32'h6);
        test_hold <= 1'b1;
        settle(3);
        chk({debug_request_pad_oe, state_enable_mirror}, 5'h06);
        bus(1'b0, crd_pkg::ADDR_STATUS, 32'h0);
        chk(q[9:8], 2'h2);
        test_hold <= 1'b0;
    endtask
    task automatic t_session();
        debug_request_n <= 1'b0;
        settle(2);
        chk(debug_session_n, 1'b0);
        @(posedge clk);
        debug_request_n <= 1'b1;
        bus(1'b1, crd_pkg::ADDR_CTRL, 32'h4);
        settle(2);
        chk(debug_session_n, 1'b1);
        @(posedge clk);
        {ce, halt_req, stop_req} <= 3'h3;
        settle(3);
        chk({halted, stopped}, 2'h0);
        @(posedge clk);
        ce <= 1'b1;
        settle(1);
        chk({halted, stopped}, 2'h3);
        @(posedge clk);
        {halt_req, rsrv_set, rsrv_clr} <= 3'h3;
        settle(1);
        chk({halted, stopped, reservation}, 3'h3);
        @(posedge clk);
        {stop_req, full_debug_enable, rsrv_set} <= 3'h0;
        settle(1);
        chk({stopped, reservation}, 2'h0);
        @(posedge clk);
        rsrv_clr <= 1'b0;
    endtask
    task automatic t_lowpower(input logic [1:0] m);
        bus(1'b1, crd_pkg::ADDR_CTRL, {30'h0, m});
        settle(1);
        chk({wakeup, sleep, nap, doze}, 4'h1 << (m - 1));
        bus(1'b1, crd_pkg::ADDR_CTRL, 32'h0);
        {ext_int_n, crit_int_n, debug_request_n} <= ~(3'h4 >> (m - 1));
        slow <= (m == 2'h3);
        wait_for(0, 1'b1);
        @(posedge clk);
        {ext_int_n, crit_int_n, debug_request_n} <= 3'h7;
        wait_for(0, 1'b0);
        chk({wakeup, sleep, nap, doze}, 4'h0);
    endtask
    task automatic t_ir();
        logic [3:0] pat;
        pat = 4'hB;
        @(posedge clk);
        tap_shift_ir <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            key_in <= pat[i];
            settle(1);
            chk(tdo, pat[i]);
            @(posedge clk);
        end
        {full_debug_enable, tap_capture_ir, tap_shift_ir} <= 3'h6;
        @(posedge clk);
        {tap_capture_ir, tap_shift_ir, tdi} <= 3'h3;
        settle(1);
        chk(tdo, 1'b1);
        repeat (3) @(posedge clk);
        tap_shift_ir <= 1'b0;
        bus(1'b0, crd_pkg::ADDR_DBG_CTRL, 32'h0);
        chk(q[7:4], 4'hF);
    endtask

    initial begin
        {rst, ce, proc_hold, test_hold, slow} = 5'h1E;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        {ext_int_n, crit_int_n, debug_request_n, full_debug_enable} = 4'hF;
        {key_in, tap_capture_ir, tap_shift_ir, tdi} = 4'h0;
        {halt_req, stop_req, rsrv_set, rsrv_clr} = 4'h0;
        {endian_sel, encoding_sel} = 2'h2;
        handler_base = 30'h2345_6789;
        n_fail = 0;
        comparisons = 0;
        settle(11);
        chk({doze, nap, sleep, wakeup, debug_request_pad_oe,
            state_enable_mirror, halted, debug_session_n}, 11'h001);
        @(posedge clk);
        {rst, test_hold} <= 2'h0;
        t_boot(30'h2345_6789, 2'h2);
        t_boot(30'h1CBA_9876, 2'h1);
        t_domains();
        t_session();
        bus(1'b1, crd_pkg::ADDR_MSTATE, 32'h5);
        for (int m = 1; m < 4; m++)
            t_lowpower(m[1:0]);
        t_ir();
        tally_and_finish();
    end
endmodule
`default_nettype wire
